// ==== rtl/prd_consts.svh ====
/*
  Constants for the PHY receive decode and 10 Mb/s link block: code-groups,
  nibble values, register offsets, field positions and timing figures.
  Assumes a 40 MHz core clock; every cycle count is derived from the figures.
*/
`ifndef PRD_CONSTS_SVH
`define PRD_CONSTS_SVH

// Core clock rate in MHz.
`define PRD_CLK_MHZ 40
// Code-groups of interest in aligned 5-bit form.
`define PRD_CG_IDLE 5'h1f
`define PRD_CG_J 5'h18
`define PRD_CG_K 5'h11
`define PRD_CG_T 5'h0d
`define PRD_CG_R 5'h07
// Nibbles driven toward the MAC.
`define PRD_NIB_PREAMBLE 4'h5
`define PRD_NIB_BAD_SSD 4'he
// Consecutive idles that end a stream.
`define PRD_IDLES_TO_END 2'h2
// Inverted link pulses that flag reversed polarity.
`define PRD_POL_COUNT 2'h3
// Register byte offsets.
`define PRD_ADR_CTRL 8'h00
`define PRD_ADR_STAT 8'h04
`define PRD_ADR_FCNT 8'h08
// Control register fields and reset value.
`define PRD_CTRL_SPEED10 0
`define PRD_CTRL_FDX 1
`define PRD_CTRL_SQE_INH 2
`define PRD_CTRL_FORCE_LINK 3
`define PRD_CTRL_RESET 4'h0
// Status register fields.
`define PRD_STAT_POL 0
`define PRD_STAT_JAB 1
`define PRD_STAT_LINK10 2
`define PRD_STAT_LINK100 3
// Times as printed, in their own units.
`define PRD_SQ_WIN_NS 150
`define PRD_LINK100_US 395
`define PRD_SQE_DELAY_NS 1000
`define PRD_SQE_LEN_NS 1000
`define PRD_LP_WIDTH_NS 100
`define PRD_LP_PERIOD_MS 16
`define PRD_JAB_MS 85
`define PRD_UNJAB_MS 500
`define PRD_LINK_LOSS_MS 150
`define PRD_BIT_NS 100
`define PRD_RXCLK_TAIL_NS 500
// Cycle counts: windows round down, least times round up.
`define PRD_SQ_WIN_CYC ((`PRD_SQ_WIN_NS * `PRD_CLK_MHZ) / 1000)
`define PRD_LINK100_CYC (`PRD_LINK100_US * `PRD_CLK_MHZ)
`define PRD_SQE_DELAY_CYC ((`PRD_SQE_DELAY_NS * `PRD_CLK_MHZ + 999) / 1000)
`define PRD_SQE_LEN_CYC ((`PRD_SQE_LEN_NS * `PRD_CLK_MHZ + 999) / 1000)
`define PRD_LP_WIDTH_CYC ((`PRD_LP_WIDTH_NS * `PRD_CLK_MHZ + 999) / 1000)
`define PRD_LP_PERIOD_CYC (`PRD_LP_PERIOD_MS * `PRD_CLK_MHZ * 1000)
`define PRD_JAB_CYC (`PRD_JAB_MS * `PRD_CLK_MHZ * 1000)
`define PRD_UNJAB_CYC (`PRD_UNJAB_MS * `PRD_CLK_MHZ * 1000)
`define PRD_LINK_LOSS_CYC (`PRD_LINK_LOSS_MS * `PRD_CLK_MHZ * 1000)
`define PRD_HALF_BIT_CYC ((`PRD_BIT_NS * `PRD_CLK_MHZ) / 2000)
`define PRD_RX_END_CYC ((`PRD_BIT_NS * 3 * `PRD_CLK_MHZ) / 2000)
`define PRD_RXCLK_TAIL_CYC ((`PRD_RXCLK_TAIL_NS * `PRD_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/prd_pkg.sv ====
/*
  Types shared by the PHY receive decode and 10 Mb/s link block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package prd_pkg;
  // Receive stream states of the 100 Mb/s code-group decoder.
  typedef enum logic [2:0] {PRD_ST_IDLE, PRD_ST_J, PRD_ST_PKT, PRD_ST_T, PRD_ST_BAD} prd_dec_e;
  // Smart squelch states.
  typedef enum logic [1:0] {PRD_SQ_OFF, PRD_SQ_FIRST, PRD_SQ_OPP, PRD_SQ_VALID} prd_sq_e;
endpackage : prd_pkg

// ==== rtl/prd_phy_core.sv ====
/*
  PHY receive decode and 10 Mb/s link core: 5B/4B decoding, 100 Mb/s link
  monitor, bad start detection, squelch, collision, heartbeat, carrier sense,
  link pulses, jabber, polarity and Manchester transmit, behind a classic
  Wishbone slave. Assumes aligned code-groups with a one-cycle strobe from
  logic on clk_i; every pin and the MII transmit side are synchronised here.
*/
// Operation
// - Decode code-groups; J/K becomes two preamble nibbles.
// - Decode until T/R or two idles.
// - Link up after 395 us steady signal detect.
// - Idle to non-idle without J/K is bad.
// - Bad start drives error and 1110 until idles.
// - Each bad start adds one to counter.
// - Two idles after bad start drop error, carrier.
// - Full duplex never signals collision.
// - Squelch needs threshold, opposite, original within 150 ns.
// - Data valid until 150 ns quiet; lower thresholds.
// - Half duplex collision on overlap or jabber.
// - Heartbeat pulse 1 us after transmit, inhibitable.
// - Carrier on transmit or receive by duplex.
// - Link pulse 100 ns every 16 ms idle.
// - No link pulses disables 10 Mb/s unless forced.
// - Jabber cuts 85 ms transmit, 500 ms unjab.
// - Three inverted pulses latch polarity, invert data.
// - Encode Manchester from transmit enable rise to fall.
// - Last line transition of frame is positive.
// - Frame end within 1.5 bits; clock five more.
// - Start pair is 11000 10001.
// - Idle code-group is 11111.
`timescale 1ns/10ps
`include "prd_consts.svh"

module prd_phy_core import prd_pkg::*; #(
  parameter int LINK100_CYC = `PRD_LINK100_CYC,
  parameter int LP_PERIOD_CYC = `PRD_LP_PERIOD_CYC,
  parameter int JAB_CYC = `PRD_JAB_CYC,
  parameter int UNJAB_CYC = `PRD_UNJAB_CYC,
  parameter int LINK_LOSS_CYC = `PRD_LINK_LOSS_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Aligned code-groups from the alignment stage.
  input wire logic [4:0] cg_i,
  input wire logic cg_valid_i,
  // Pins: signal detect, squelch comparators, link pulses, received line.
  input wire logic sig_det_i,
  input wire logic sq_pos_i,
  input wire logic sq_neg_i,
  input wire logic lp_pos_i,
  input wire logic lp_neg_i,
  input wire logic line_rx_i,
  // MII transmit side from the MAC.
  input wire logic tx_clk_i,
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  // MII receive side toward the MAC.
  output logic [3:0] rxd_o,
  output logic rx_dv_o,
  output logic rx_er_o,
  output logic rx_clk_run_o,
  output logic crs_o,
  output logic col_o,
  // Line side outputs.
  output logic line_tx_o,
  output logic line_tx_act_o,
  output logic link_pulse_o,
  output logic sq_low_thr_o,
  output logic line_rx_fixed_o,
  output logic link100_o,
  output logic link10_o
);

  // Number of synchronised pins.
  localparam int NSYNC = 12;

  // Decodes a data code-group to {valid, nibble}.
  function automatic logic [4:0] dec5b(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    case (cg)
      5'h1e: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0a: r = 5'h14;
      5'h0b: r = 5'h15;
      5'h0e: r = 5'h16;
      5'h0f: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1a;
      5'h17: r = 5'h1b;
      5'h1a: r = 5'h1c;
      5'h1b: r = 5'h1d;
      5'h1c: r = 5'h1e;
      5'h1d: r = 5'h1f;
      default: r = 5'h00;
    endcase
    return r;
  endfunction : dec5b

  // Two-flop synchronisers for every pin from outside the clock domain.
  logic [NSYNC-1:0] sync_a; // First stage, read only by the second.
  logic [NSYNC-1:0] sync_b; // Stable copies.
  logic [NSYNC-1:0] pins;
  assign pins = {txd_i, tx_en_i, tx_clk_i, line_rx_i, lp_neg_i, lp_pos_i, sq_neg_i, sq_pos_i, sig_det_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        sync_a[gi] <= rst_i ? 1'b0 : pins[gi];
        sync_b[gi] <= rst_i ? 1'b0 : sync_a[gi];
      end
    end
  endgenerate
  wire sd_s = sync_b[0];
  wire sqp_s = sync_b[1];
  wire sqn_s = sync_b[2];
  wire lpp_s = sync_b[3];
  wire lpn_s = sync_b[4];
  wire lrx_s = sync_b[5];
  wire tck_s = sync_b[6];
  wire ten_s = sync_b[7];
  wire [3:0] txd_s = sync_b[11:8];

  // Edge history for pins whose edges matter.
  logic sqp_d, sqn_d, lpp_d, lpn_d, lrx_d, tck_d;
  always_ff @(posedge clk_i) begin
    {sqp_d, sqn_d, lpp_d, lpn_d, lrx_d, tck_d} <= rst_i ? 6'h00 : {sqp_s, sqn_s, lpp_s, lpn_s, lrx_s, tck_s};
  end
  wire sqp_rise = sqp_s & ~sqp_d;
  wire sqn_rise = sqn_s & ~sqn_d;
  wire lpp_rise = lpp_s & ~lpp_d;
  wire lpn_rise = lpn_s & ~lpn_d;
  wire tck_rise = tck_s & ~tck_d;

  // Software state.
  logic [3:0] ctrl; // Speed, duplex, SQE inhibit, forced link.
  logic pol_rev; // Latched reversed polarity.
  logic [15:0] false_carrier_event_counter;
  wire speed10 = ctrl[`PRD_CTRL_SPEED10];
  wire fdx = ctrl[`PRD_CTRL_FDX];

  // Bus decode as named wires; unmapped addresses read zero.
  wire hit_ctrl = wb_adr_i == `PRD_ADR_CTRL;
  wire hit_stat = wb_adr_i == `PRD_ADR_STAT;
  wire hit_fcnt = wb_adr_i == `PRD_ADR_FCNT;
  wire wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  logic [31:0] rd_mux;
  logic jab;
  assign rd_mux = hit_ctrl ? {28'h0000000, ctrl} :
                  hit_stat ? {28'h0000000, link100_o, link10_o, jab, pol_rev} :
                  hit_fcnt ? {16'h0000, false_carrier_event_counter} : 32'h00000000;

  // Answers one cycle after a request shows, drops ack the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // Control register; written at the edge where the master sees ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `PRD_CTRL_RESET;
    end else if (wr_go && hit_ctrl) begin
      ctrl <= wb_dat_i[3:0];
    end
  end

  // 100 Mb/s link monitor: signal detect must hold the whole interval.
  logic [$clog2(LINK100_CYC+1)-1:0] sd_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !sd_s) begin
      sd_cnt <= '0;
      link100_o <= 1'b0;
    end else if (sd_cnt == LINK100_CYC[$bits(sd_cnt)-1:0]) begin
      link100_o <= 1'b1;
    end else begin
      sd_cnt <= sd_cnt + 1'b1;
    end
  end

  // Code-group decoder state.
  prd_dec_e dst;
  logic [1:0] idle_run; // Consecutive idles, saturating.
  wire cg_idle = cg_i == `PRD_CG_IDLE;
  wire [4:0] cg_dec = dec5b(cg_i);
  wire cg_go = cg_valid_i & link100_o & ~speed10;
  wire two_idle = cg_idle && idle_run >= `PRD_IDLES_TO_END - 2'h1;
  wire bad_start = cg_go && dst == PRD_ST_IDLE && !cg_idle && cg_i != `PRD_CG_J && idle_run != 2'h0;
  wire bad_k = cg_go && dst == PRD_ST_J && cg_i != `PRD_CG_K;
  logic crs100;

  // Decoder sequencing; one nibble leaves per code-group.
  always_ff @(posedge clk_i) begin
    if (rst_i || !link100_o || speed10) begin
      dst <= PRD_ST_IDLE;
      idle_run <= 2'h0;
      rxd_o <= 4'h0;
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
      crs100 <= 1'b0;
    end else if (cg_go) begin
      idle_run <= cg_idle ? (idle_run == 2'h3 ? idle_run : idle_run + 2'h1) : 2'h0;
      case (dst)
        PRD_ST_IDLE: begin
          if (cg_i == `PRD_CG_J && idle_run != 2'h0) begin
            // Start pair first half becomes preamble.
            dst <= PRD_ST_J;
            rxd_o <= `PRD_NIB_PREAMBLE;
            rx_dv_o <= 1'b1;
            crs100 <= 1'b1;
          end else if (bad_start) begin
            dst <= PRD_ST_BAD;
            rxd_o <= `PRD_NIB_BAD_SSD;
            rx_er_o <= 1'b1;
            crs100 <= 1'b1;
          end
        end
        PRD_ST_J: begin
          if (!bad_k) begin
            dst <= PRD_ST_PKT;
            rxd_o <= `PRD_NIB_PREAMBLE;
          end else begin
            // A J that lacks its K is a bad start as well.
            dst <= PRD_ST_BAD;
            rxd_o <= `PRD_NIB_BAD_SSD;
            rx_dv_o <= 1'b0;
            rx_er_o <= 1'b1;
          end
        end
        PRD_ST_PKT: begin
          if (cg_i == `PRD_CG_T) begin
            dst <= PRD_ST_T;
            rx_dv_o <= 1'b0;
          end else if (two_idle) begin
            dst <= PRD_ST_IDLE;
            rx_dv_o <= 1'b0;
            rx_er_o <= 1'b0;
            crs100 <= 1'b0;
          end else if (!cg_idle) begin
            rxd_o <= cg_dec[3:0];
            rx_er_o <= ~cg_dec[4];
          end
        end
        PRD_ST_T: begin
          // Closing pair ends the stream; anything else is reported.
          dst <= PRD_ST_IDLE;
          rx_er_o <= cg_i != `PRD_CG_R;
          crs100 <= 1'b0;
        end
        PRD_ST_BAD: begin
          if (two_idle) begin
            dst <= PRD_ST_IDLE;
            rx_er_o <= 1'b0;
            crs100 <= 1'b0;
          end else begin
            rxd_o <= `PRD_NIB_BAD_SSD;
          end
        end
        default: dst <= PRD_ST_IDLE;
      endcase
    end
  end

  // False carrier counter; each bad start adds exactly one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      false_carrier_event_counter <= 16'h0000;
    end else if (bad_start || bad_k) begin
      false_carrier_event_counter <= false_carrier_event_counter + 16'h0001;
    end
  end

  // 10 Mb/s link integrity from incoming pulses, and polarity detection.
  logic [$clog2(LINK_LOSS_CYC+1)-1:0] loss_cnt;
  logic [1:0] inv_run;
  logic lp_seen_ok;
  wire lp_any = lpp_rise | lpn_rise;
  wire link10_ok = lp_seen_ok | ctrl[`PRD_CTRL_FORCE_LINK];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loss_cnt <= '0;
      lp_seen_ok <= 1'b0;
      inv_run <= 2'h0;
      pol_rev <= 1'b0;
    end else begin
      loss_cnt <= lp_any ? '0 : (loss_cnt == LINK_LOSS_CYC[$bits(loss_cnt)-1:0] ? loss_cnt : loss_cnt + 1'b1);
      lp_seen_ok <= lp_any | (lp_seen_ok & (loss_cnt != LINK_LOSS_CYC[$bits(loss_cnt)-1:0]));
      inv_run <= lpp_rise ? 2'h0 : (lpn_rise && inv_run != `PRD_POL_COUNT) ? inv_run + 2'h1 : inv_run;
      // A new detection wins over a software clear in the same cycle.
      if (lpn_rise && inv_run == `PRD_POL_COUNT - 2'h1) begin
        pol_rev <= 1'b1;
      end else if (wr_go && hit_stat && wb_dat_i[`PRD_STAT_POL]) begin
        pol_rev <= 1'b0;
      end
    end
  end

  // Smart squelch qualification and end-of-packet timing.
  prd_sq_e sq;
  logic sq_first_pos; // Which threshold opened the sequence.
  logic [3:0] sq_tmr;
  wire sq_any = sqp_rise | sqn_rise;
  wire sq_opp = sq_first_pos ? sqn_rise : sqp_rise;
  wire sq_same = sq_first_pos ? sqp_rise : sqn_rise;
  wire sq_late = sq_tmr >= 4'(`PRD_SQ_WIN_CYC);
  always_ff @(posedge clk_i) begin
    if (rst_i || !link10_ok) begin
      sq <= PRD_SQ_OFF;
      sq_first_pos <= 1'b0;
      sq_tmr <= 4'h0;
    end else begin
      sq_tmr <= (sq_any || sq_late) ? 4'h0 : sq_tmr + 4'h1;
      case (sq)
        PRD_SQ_OFF: if (sq_any) begin
          sq <= PRD_SQ_FIRST;
          sq_first_pos <= sqp_rise;
        end
        PRD_SQ_FIRST: if (sq_opp) begin
          sq <= PRD_SQ_OPP;
        end else if (sq_late) begin
          sq <= PRD_SQ_OFF;
        end
        PRD_SQ_OPP: if (sq_same) begin
          sq <= PRD_SQ_VALID;
        end else if (sq_late) begin
          sq <= PRD_SQ_OFF;
        end
        PRD_SQ_VALID: if (sq_late && !sq_any) begin
          sq <= PRD_SQ_OFF;
        end
        default: sq <= PRD_SQ_OFF;
      endcase
    end
  end
  wire rx10 = sq == PRD_SQ_VALID;

  // Receive line end detection from missing transitions; clock tail.
  logic [2:0] quiet;
  logic [4:0] tail;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quiet <= 3'h0;
      tail <= 5'h00;
      rx_clk_run_o <= 1'b0;
      line_rx_fixed_o <= 1'b0;
      sq_low_thr_o <= 1'b0;
    end else begin
      quiet <= (lrx_s != lrx_d) ? 3'h0 : (quiet == 3'(`PRD_RX_END_CYC) ? quiet : quiet + 3'h1);
      tail <= (rx10 && quiet != 3'(`PRD_RX_END_CYC)) ? 5'(`PRD_RXCLK_TAIL_CYC) : (tail != 5'h00 ? tail - 5'h01 : tail);
      rx_clk_run_o <= rx10 || tail != 5'h00;
      line_rx_fixed_o <= lrx_s ^ pol_rev;
      sq_low_thr_o <= rx10;
    end
  end
  wire rx10_act = rx10 && quiet != 3'(`PRD_RX_END_CYC);

  // Jabber: long transmit cuts the driver until enable rests long enough.
  logic [$clog2(JAB_CYC+1)-1:0] jab_cnt;
  logic [$clog2(UNJAB_CYC+1)-1:0] unjab_cnt;
  wire tx_req = ten_s & link10_ok & speed10;
  always_ff @(posedge clk_i) begin
    if (rst_i || !speed10) begin
      jab <= 1'b0;
      jab_cnt <= '0;
      unjab_cnt <= '0;
    end else begin
      jab_cnt <= tx_req ? (jab_cnt == JAB_CYC[$bits(jab_cnt)-1:0] ? jab_cnt : jab_cnt + 1'b1) : '0;
      unjab_cnt <= tx_req ? '0 : (unjab_cnt == UNJAB_CYC[$bits(unjab_cnt)-1:0] ? unjab_cnt : unjab_cnt + 1'b1);
      if (jab_cnt == JAB_CYC[$bits(jab_cnt)-1:0]) begin
        jab <= 1'b1;
      end else if (unjab_cnt == UNJAB_CYC[$bits(unjab_cnt)-1:0]) begin
        jab <= 1'b0;
      end
    end
  end

  // Manchester encoder: nibbles load on transmit clock rises.
  logic [3:0] sh; // Bits left of the current nibble.
  logic [2:0] nbits;
  logic [2:0] ph; // Half-bit phase counter.
  logic half; // Second half of the bit cell.
  logic tx_on, tail_hi;
  logic [7:0] sqe_tmr;
  wire tx_send = tx_req & ~jab;
  wire ph_end = ph == 3'(`PRD_HALF_BIT_CYC - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh <= 4'h0;
      nbits <= 3'h0;
      ph <= 3'h0;
      half <= 1'b0;
      tx_on <= 1'b0;
      tail_hi <= 1'b0;
      line_tx_o <= 1'b0;
      line_tx_act_o <= 1'b0;
    end else begin
      ph <= ph_end ? 3'h0 : ph + 3'h1;
      if (tx_send && tck_rise) begin
        sh <= txd_s;
        nbits <= 3'h4;
        tx_on <= 1'b1;
      end else if (ph_end && half && nbits != 3'h0) begin
        sh <= {1'b0, sh[3:1]};
        nbits <= nbits - 3'h1;
      end
      if (ph_end) begin
        half <= ~half;
      end
      if (tx_on && nbits != 3'h0) begin
        // First half carries the inverse, second half the bit.
        line_tx_o <= half ? sh[0] : ~sh[0];
        line_tx_act_o <= 1'b1;
        tail_hi <= 1'b1;
      end else if (tx_on && !tx_send && tail_hi) begin
        // Closing positive edge: at mid-cell after a one, at cell end after a zero.
        line_tx_o <= 1'b1;
        tail_hi <= ~(ph_end && half);
        tx_on <= ~(ph_end && half);
      end else begin
        line_tx_act_o <= tx_on | link_pulse_o;
        line_tx_o <= link_pulse_o;
      end
    end
  end

  // Link pulses while no transmit is pending, and the heartbeat pulse.
  logic [$clog2(LP_PERIOD_CYC+1)-1:0] lp_cnt;
  logic sqe_armed;
  wire sqe_ok = ~fdx & ~ctrl[`PRD_CTRL_SQE_INH];
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_on || !speed10) begin
      lp_cnt <= '0;
      link_pulse_o <= 1'b0;
    end else begin
      lp_cnt <= lp_cnt == LP_PERIOD_CYC[$bits(lp_cnt)-1:0] ? '0 : lp_cnt + 1'b1;
      link_pulse_o <= lp_cnt < LP_PERIOD_CYC[$bits(lp_cnt)-1:0] && lp_cnt >= ($bits(lp_cnt))'(LP_PERIOD_CYC - `PRD_LP_WIDTH_CYC);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_send) begin
      sqe_armed <= tx_send;
      sqe_tmr <= 8'h00;
    end else if (sqe_armed) begin
      sqe_tmr <= sqe_tmr + 8'h01;
      sqe_armed <= sqe_tmr != 8'(`PRD_SQE_DELAY_CYC + `PRD_SQE_LEN_CYC - 1);
    end
  end
  wire sqe_on = sqe_armed && sqe_tmr >= 8'(`PRD_SQE_DELAY_CYC) && sqe_ok;

  // MII carrier and collision, steered by speed and duplex.
  wire col10 = speed10 & link10_ok & ~fdx & ((tx_req & rx10_act) | jab);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crs_o <= 1'b0;
      col_o <= 1'b0;
      link10_o <= 1'b0;
    end else begin
      crs_o <= speed10 ? (rx10_act | (tx_req & ~fdx)) : crs100;
      col_o <= col10 | (speed10 & sqe_on);
      link10_o <= link10_ok;
    end
  end

endmodule : prd_phy_core

// ==== testbench/prd_phy_checker.sv ====
/* Assertions on the top ports of the receive decode and link core.
   Assumes a bind from the bench and aligned, one-cycle code-group strobes. */
`timescale 1ns/10ps
`include "prd_consts.svh"

module prd_phy_checker #(
  parameter int LINK100_CYC = 20
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshake.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Code-group stream and signal detect.
  input wire logic [4:0] cg_i,
  input wire logic cg_valid_i,
  input wire logic sig_det_i,
  // Receive and link outputs.
  input wire logic [3:0] rxd_o,
  input wire logic rx_dv_o,
  input wire logic rx_er_o,
  input wire logic crs_o,
  input wire logic link_pulse_o,
  input wire logic link100_o
);
  logic [4:0] last_cg; // Group of the previous strobe.
  logic [1:0] idle_run; // Idle strobes just before this one, held at two.
  int sd_cnt; // Cycles that signal detect has stood high.
  wire taken = cg_valid_i && link100_o; // A strobe the decoder accepts while speed10 is clear.
  wire is_idle = cg_i == `PRD_CG_IDLE; // The present group is idle.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Keeps a short history of the stream and of signal detect.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_cg <= 5'h00;
      idle_run <= 2'h0;
      sd_cnt <= 0;
    end else begin
      sd_cnt <= sig_det_i ? sd_cnt + 1 : 0;
      if (cg_valid_i) begin
        last_cg <= cg_i;
        idle_run <= !is_idle ? 2'h0 : (idle_run[1] ? 2'h2 : idle_run + 2'h1);
      end
    end
  end
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack stood longer than one cycle");
  ack_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not answered");
  link_up_a:
    assert property ($rose(link100_o) |-> sd_cnt >= LINK100_CYC) else $error("link up too early");
  preamble_j_a:
    assert property (taken && cg_i == `PRD_CG_J && idle_run == 2'h2 |=> rx_dv_o && rxd_o == 4'h5 ##1 crs_o)
    else $error("start group not turned into preamble");
  preamble_k_a:
    assert property (taken && cg_i == `PRD_CG_K && last_cg == `PRD_CG_J |=> rx_dv_o && rxd_o == 4'h5)
    else $error("second start group not turned into preamble");
  bad_start_a:
    assert property (taken && idle_run == 2'h2 && !is_idle && cg_i != `PRD_CG_J |=> rx_er_o && rxd_o == 4'he)
    else $error("bad start not flagged");
  idle_end_a:
    assert property (taken && is_idle && idle_run != 2'h0 |=> !rx_er_o && !rx_dv_o ##1 !crs_o)
    else $error("two idles did not end the stream");
  link_pulse_a:
    assert property ($rose(link_pulse_o) |=> link_pulse_o [*3] ##1 !link_pulse_o)
    else $error("link pulse width wrong");
endmodule : prd_phy_checker

// ==== testbench/prd_mac_model.sv ====
/* Transmit side of a MAC on the media independent interface.
   Assumes the core samples the transmit clock with its own clock. */
`timescale 1ns/10ps

module prd_mac_model (
  // Transmit outputs toward the core.
  output logic tx_clk_o,
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  // The transmit clock stands still low between frames.
  initial {tx_clk_o, tx_en_o, txd_o} = 6'h00;
  // Sends n counting nibbles; data moves on each falling edge.
  task automatic send(input int n);
    #7 tx_en_o = 1'b1;
    txd_o = 4'h0;
    for (int i = 1; i <= n; i++) begin
      #100 tx_clk_o = 1'b1;
      #100 tx_clk_o = 1'b0;
      txd_o = i[3:0];
      tx_en_o = i < n;
    end
    txd_o = ~txd_o; // Released data never shows its last value.
  endtask : send
endmodule : prd_mac_model

// ==== testbench/tb_top.sv ====
/* Bench for the receive decode and 10 Mb/s link core.
   Assumes the checker and the MAC model are compiled first. */
`timescale 1ns/10ps
`include "prd_consts.svh"

module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic cg_valid_i = 0, sig_det_i = 0, sq_pos_i = 0, sq_neg_i = 0, lp_pos_i = 0, lp_neg_i = 0, line_rx_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0;
  logic [4:0] cg_i = 0;
  logic [31:0] wb_dat_o;
  logic [3:0] rxd_o, txd_i;
  logic wb_ack_o, rx_dv_o, rx_er_o, rx_clk_run_o, crs_o, col_o, line_tx_o, line_tx_act_o, link_pulse_o;
  logic sq_low_thr_o, line_rx_fixed_o, link100_o, link10_o, tx_clk_i, tx_en_i;
  int errors = 0, n_tests = 0, n_col = 0, n_lp = 0;
  logic [4:0] tbl [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  always #12.5 clk_i = ~clk_i;
  prd_phy_core #(.LINK100_CYC(20), .LP_PERIOD_CYC(100), .JAB_CYC(200), .UNJAB_CYC(300), .LINK_LOSS_CYC(2000)) DUT (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .cg_i, .cg_valid_i, .sig_det_i, .sq_pos_i, .sq_neg_i, .lp_pos_i, .lp_neg_i, .line_rx_i, .tx_clk_i,
    .tx_en_i, .txd_i, .rxd_o, .rx_dv_o, .rx_er_o, .rx_clk_run_o, .crs_o, .col_o, .line_tx_o, .line_tx_act_o,
    .link_pulse_o, .sq_low_thr_o, .line_rx_fixed_o, .link100_o, .link10_o);
  prd_mac_model mac (.tx_clk_o(tx_clk_i), .tx_en_o(tx_en_i), .txd_o(txd_i));
  // Counts cycles of collision and of link pulse.
  always @(posedge clk_i) begin
    if (!rst_i) begin
      n_col <= n_col + col_o;
      n_lp <= n_lp + link_pulse_o;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  // One classic bus cycle, held until ack.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, 4'hf, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    chk(wb_ack_o, 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd
  // Sends one group and compares valid, error and nibble under a mask.
  task automatic cg(input logic [4:0] c, input logic [5:0] e, input logic [5:0] m = 6'h3f);
    @(posedge clk_i);
    cg_i <= c;
    cg_valid_i <= 1'b1;
    @(posedge clk_i);
    cg_valid_i <= 1'b0;
    #1 chk({rx_dv_o, rx_er_o, rxd_o} & m, e);
  endtask : cg
  // Sends a frame under a mode, checks carrier mid-frame and collision cycles after.
  task automatic frame(input logic [3:0] c, input logic ec, input int ecol);
    int n0;
    wr(`PRD_ADR_CTRL, {28'h0, c});
    n0 = n_col;
    fork
      mac.send(6);
      begin
        repeat (30) @(posedge clk_i);
        chk(crs_o, ec);
      end
    join
    repeat (150) @(posedge clk_i);
    chk(n_col - n0, ecol);
  endtask : frame
  task automatic finish_test;
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6000) @(posedge clk_i);
    errors++;
    finish_test();
  end
  initial begin
    int k;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`PRD_ADR_CTRL, 32'h0);
    rd(`PRD_ADR_FCNT, 32'h0);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h0);
    sig_det_i <= 1'b1;
    repeat (15) @(posedge clk_i);
    chk(link100_o, 1'b0);
    repeat (15) @(posedge clk_i);
    chk(link100_o, 1'b1);
    repeat (2) cg(`PRD_CG_IDLE, 6'h00, 6'h30);
    cg(`PRD_CG_J, 6'h25);
    cg(`PRD_CG_K, 6'h25);
    for (int i = 0; i < 16; i++) cg(tbl[i], {2'h2, i[3:0]});
    cg(5'h00, 6'h10, 6'h10);
    cg(`PRD_CG_T, 6'h00, 6'h20);
    cg(`PRD_CG_R, 6'h00, 6'h30);
    repeat (2) begin
      repeat (2) cg(`PRD_CG_IDLE, 6'h00, 6'h30);
      cg(5'h0e, 6'h1e, 6'h1f);
      cg(5'h0e, 6'h1e, 6'h1f);
      cg(`PRD_CG_IDLE, 6'h00, 6'h00);
      cg(`PRD_CG_IDLE, 6'h00, 6'h30);
      @(posedge clk_i);
      #1 chk(crs_o, 1'b0);
    end
    rd(`PRD_ADR_FCNT, 32'h2);
    wr(`PRD_ADR_CTRL, 32'h1);
    repeat (10) @(posedge clk_i);
    chk(link10_o, 1'b0);
    wr(`PRD_ADR_CTRL, 32'h9);
    rd(`PRD_ADR_CTRL, 32'h9);
    chk(link10_o, 1'b1);
    k = n_lp;
    repeat (200) @(posedge clk_i);
    chk(n_lp - k, 8);
    frame(4'h9, 1'b1, 40);
    frame(4'hd, 1'b1, 0);
    frame(4'hb, 1'b0, 0);
    wr(`PRD_ADR_CTRL, 32'h9);
    fork
      mac.send(40);
      begin
        repeat (280) @(posedge clk_i);
        chk(col_o, 1'b1);
      end
    join
    rd(`PRD_ADR_STAT, 32'h2, 32'h2);
    repeat (320) @(posedge clk_i);
    rd(`PRD_ADR_STAT, 32'h0, 32'h2);
    repeat (12) @(posedge clk_i) {sq_pos_i, sq_neg_i, line_rx_i, lp_pos_i} <= {~sq_pos_i, sq_pos_i, ~line_rx_i, line_rx_i};
    chk({crs_o, sq_low_thr_o}, 2'h3);
    repeat (12) @(posedge clk_i);
    chk(crs_o, 1'b0);
    repeat (3) begin
      @(posedge clk_i);
      lp_neg_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      lp_neg_i <= 1'b0;
      repeat (20) @(posedge clk_i);
    end
    rd(`PRD_ADR_STAT, 32'h1, 32'h1);
    chk(line_rx_fixed_o, 1'b1);
    wr(`PRD_ADR_STAT, 32'h1);
    rd(`PRD_ADR_STAT, 32'h0, 32'h1);
    finish_test();
  end
endmodule : tb_top

bind prd_phy_core prd_phy_checker #(.LINK100_CYC(LINK100_CYC)) u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cg_i, .cg_valid_i,
  .sig_det_i, .rxd_o, .rx_dv_o, .rx_er_o, .crs_o, .link_pulse_o, .link100_o);
